// File: evp_top.sv
// Exception vectoring and priority unit with AXI4-Lite register slave
//
// How it works
// R1 - Table entry zero is stack pointer, then handlers
// R2 - Interrupt k is exception 16+k, offset 0x40+4k
// R3 - Software sets bit zero of handler addresses
// R4 - Table base is zero after reset
// R5 - Privileged write relocates table base within range
// R6 - Write drops low eight bits, so table base is 256-byte aligned
// R7 - Smaller value more urgent; three fixed levels
// R8 - Configurable priorities reset to zero
// R9 - Configurable priorities are 0-7, below fixed ones
// R10 - Equal level: smallest exception number first
// R11 - Strictly more urgent pending request preempts handler
// R12 - Equal level never preempts; stays pending
// R13 - NMI always enabled, level -2, reset-only preemption
// R14 - Hard fault level -1, reset level -3
// R15 - Sampled request sets pending until taken or cleared
`timescale 1ns/100ps
`default_nettype none
module evp_top (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // Interrupt sources
  input  wire logic [43:0] i_irq,
  input  wire logic        i_nmi,
  input  wire logic [15:0] i_sys_exc,
  // Core exception entry and return
  output logic             o_exc_req,
  output logic [5:0]       o_exc_num,
  output logic [31:0]      o_vec_addr,
  input  wire logic        i_exc_ack,
  input  wire logic        i_exc_ret,
  input  wire logic [5:0]  i_ret_num,
  output logic [31:0]      o_sp_fetch_addr,
  output logic [31:0]      o_reset_fetch_addr,
  // AXI4-Lite slave
  input  wire logic [7:0]  i_s_axi_awaddr,
  input  wire logic [2:0]  i_s_axi_awprot,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [7:0]  i_s_axi_araddr,
  input  wire logic [2:0]  i_s_axi_arprot,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready
);

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  typedef struct packed {
    logic [43:0]      irq_s1;
    logic [43:0]      irq_s2;
    logic             nmi_s1;
    logic             nmi_s2;
    logic [59:0]      pend;
    logic [59:0]      act;
    logic [43:0]      en;
    logic [59:0][2:0] prio;
    logic [31:0]      base;
    logic             req;
    logic [5:0]       num;
    logic [31:0]      vaddr;
    logic             aw_full;
    logic [7:0]       aw_addr;
    logic             aw_priv;
    logic             w_full;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } evp_state_t;

  evp_state_t s_reg;
  evp_state_t s_next;

  evp_arb_if #(.N(60), .LW(4), .NW(6)) arb_p ();
  evp_arb_if #(.N(60), .LW(4), .NW(6)) arb_a ();

  logic [3:0]  act_lvl;
  logic        win_ok;
  logic        ack;
  logic        wr_go;
  logic [31:0] wmask;
  logic [31:0] wmerge;
  logic [31:0] rd_word;
  logic [59:0] sw_set;
  logic [59:0] sw_clr;
  logic [59:0] hw_set;
  logic [59:0] take_clr;
  logic [31:0] prio_img;
  logic [5:0]  fld_num;
  logic [5:0]  wfld_num;

  // -----------------------------------------------------------------------
  // Urgency ranks and arbitration
  // -----------------------------------------------------------------------
  for (genvar g = 0; g < evp_pkg::NUM_EXC; g++) begin : g_lvl
    if (6'(g) == evp_pkg::EXC_NMI) begin : g_nmi
      assign arb_p.lvl[g] = evp_pkg::LVL_NMI; // [R13]
    end else if (6'(g) == evp_pkg::EXC_HARD) begin : g_hard
      assign arb_p.lvl[g] = evp_pkg::LVL_HARD; // [R14]
    end else begin : g_cfg
      // Configurable 0-7 sits behind every fixed rank
      assign arb_p.lvl[g] = evp_pkg::LVL_CFG0 + {1'b0, s_reg.prio[g]}; // [R7] [R9]
    end
    assign arb_a.lvl[g] = arb_p.lvl[g];
  end

  // System exceptions and NMI are never gated by an enable
  assign arb_p.req = s_reg.pend & {s_reg.en, 16'hffff} & evp_pkg::IMPL_MASK; // [R13]
  assign arb_a.req = s_reg.act;

  evp_arbiter #(.N(60), .LW(4), .NW(6)) u_arb_pend (.arb(arb_p));
  evp_arbiter #(.N(60), .LW(4), .NW(6)) u_arb_act (.arb(arb_a));

  assign act_lvl = arb_a.found ? arb_a.win_lvl : evp_pkg::LVL_THREAD;
  // Strict compare: an equal rank waits pending
  assign win_ok  = arb_p.found && (arb_p.win_lvl < act_lvl); // [R11] [R12]
  assign ack     = s_reg.req && i_exc_ack;

  // -----------------------------------------------------------------------
  // Register read image
  // -----------------------------------------------------------------------
  always_comb begin
    prio_img = '0;
    fld_num  = '0;
    for (int f = 0; f < 8; f++) begin
      fld_num = {i_s_axi_araddr[4:2], 3'(f)};
      if (fld_num < 6'(evp_pkg::NUM_EXC)) begin
        prio_img[4*f +: 3] = s_reg.prio[fld_num];
      end
    end
    rd_word = '0;
    if (i_s_axi_araddr[7:5] == evp_pkg::OFS_PRIO_HI) begin
      rd_word = prio_img;
    end else begin
      unique case (i_s_axi_araddr)
        evp_pkg::OFS_VECBASE: rd_word = s_reg.base;
        evp_pkg::OFS_EN_LO:   rd_word = s_reg.en[31:0];
        evp_pkg::OFS_EN_HI:   rd_word = {20'h0, s_reg.en[43:32]};
        evp_pkg::OFS_PSET_LO,
        evp_pkg::OFS_PCLR_LO: rd_word = s_reg.pend[31:0];
        evp_pkg::OFS_PSET_HI,
        evp_pkg::OFS_PCLR_HI: rd_word = {4'h0, s_reg.pend[59:32]};
        evp_pkg::OFS_ACT_LO:  rd_word = s_reg.act[31:0];
        evp_pkg::OFS_ACT_HI:  rd_word = {4'h0, s_reg.act[59:32]};
        evp_pkg::OFS_STATUS: begin
          rd_word[evp_pkg::ST_ACT_NUM +: 6]  = arb_a.win_num;
          rd_word[evp_pkg::ST_ACT_LVL +: 4]  = act_lvl;
          rd_word[evp_pkg::ST_PEND_NUM +: 6] = arb_p.win_num;
          rd_word[evp_pkg::ST_PEND_LVL +: 4] = arb_p.win_lvl;
          rd_word[evp_pkg::ST_PEND_OK]       = arb_p.found;
        end
        default: rd_word = '0;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  always_comb begin
    s_next   = s_reg;
    wr_go    = s_reg.aw_full && s_reg.w_full && !s_reg.bvalid;
    wmask    = {{8{s_reg.w_strb[3]}}, {8{s_reg.w_strb[2]}},
                {8{s_reg.w_strb[1]}}, {8{s_reg.w_strb[0]}}};
    wmerge   = '0;
    sw_set   = '0;
    sw_clr   = '0;
    take_clr = '0;
    wfld_num = '0;

    // Two-stage synchronisers for pins
    s_next.irq_s1 = i_irq;
    s_next.irq_s2 = s_reg.irq_s1;
    s_next.nmi_s1 = i_nmi;
    s_next.nmi_s2 = s_reg.nmi_s1;

    // AXI write channels accepted in either order
    if (i_s_axi_awvalid && o_s_axi_awready) begin
      s_next.aw_full = 1'b1;
      s_next.aw_addr = i_s_axi_awaddr;
      s_next.aw_priv = i_s_axi_awprot[0];
    end
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      s_next.w_full = 1'b1;
      s_next.w_data = i_s_axi_wdata;
      s_next.w_strb = i_s_axi_wstrb;
    end
    if (s_reg.bvalid && i_s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end

    if (wr_go) begin
      s_next.aw_full = 1'b0;
      s_next.w_full  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = evp_pkg::RESP_OKAY;
      if (s_reg.aw_addr[7:5] == evp_pkg::OFS_PRIO_HI) begin
        for (int f = 0; f < 8; f++) begin
          wfld_num = {s_reg.aw_addr[4:2], 3'(f)};
          if (wfld_num < 6'(evp_pkg::NUM_EXC) && evp_pkg::CFG_MASK[wfld_num]) begin
            // Only three bits are stored, so 0-7 is all a level can be
            if (wmask[4*f]) begin
              s_next.prio[wfld_num] = s_reg.w_data[4*f +: 3]; // [R9]
            end
          end
        end
      end else begin
        unique case (s_reg.aw_addr)
          evp_pkg::OFS_VECBASE: begin
            if (s_reg.aw_priv) begin
              wmerge      = (s_reg.base & ~wmask) | (s_reg.w_data & wmask);
              s_next.base = wmerge & evp_pkg::BASE_MASK; // [R5] [R6]
            end else begin
              s_next.bresp = evp_pkg::RESP_SLVERR;
            end
          end
          evp_pkg::OFS_EN_LO: begin
            wmerge         = (s_reg.en[31:0] & ~wmask) | (s_reg.w_data & wmask);
            s_next.en[31:0] = wmerge & evp_pkg::IMPL_MASK[47:16];
          end
          evp_pkg::OFS_EN_HI: begin
            wmerge = ({20'h0, s_reg.en[43:32]} & ~wmask) | (s_reg.w_data & wmask);
            s_next.en[43:32] = wmerge[11:0] & evp_pkg::IMPL_MASK[59:48];
          end
          evp_pkg::OFS_PSET_LO: sw_set[31:0]  = s_reg.w_data & wmask;
          evp_pkg::OFS_PSET_HI: sw_set[59:32] = s_reg.w_data[27:0] & wmask[27:0];
          evp_pkg::OFS_PCLR_LO: sw_clr[31:0]  = s_reg.w_data & wmask;
          evp_pkg::OFS_PCLR_HI: sw_clr[59:32] = s_reg.w_data[27:0] & wmask[27:0];
          evp_pkg::OFS_STATUS,
          evp_pkg::OFS_ACT_LO,
          evp_pkg::OFS_ACT_HI: s_next.bresp = evp_pkg::RESP_OKAY;
          default: s_next.bresp = evp_pkg::RESP_DECERR;
        endcase
      end
    end

    // AXI read
    if (s_reg.rvalid && i_s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (i_s_axi_arvalid && o_s_axi_arready) begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = rd_word;
      s_next.rresp  = ((i_s_axi_araddr[7:5] == evp_pkg::OFS_PRIO_HI) ||
                       (i_s_axi_araddr <= evp_pkg::OFS_ACT_HI && i_s_axi_araddr[1:0] == 2'h0))
                      ? evp_pkg::RESP_OKAY : evp_pkg::RESP_DECERR;
    end

    // Pending: a set in the same cycle as a clear wins
    hw_set = {s_reg.irq_s2, 16'h0} | {44'h0, i_sys_exc}; // [R15] [R2]
    hw_set[evp_pkg::EXC_NMI] = hw_set[evp_pkg::EXC_NMI] | s_reg.nmi_s2;
    if (ack) begin
      take_clr[s_reg.num] = 1'b1;
      s_next.act[s_reg.num] = 1'b1;
    end
    if (i_exc_ret) begin
      s_next.act[i_ret_num] = 1'b0;
    end
    s_next.pend = ((s_reg.pend & ~(sw_clr | take_clr)) | hw_set | sw_set)
                  & evp_pkg::IMPL_MASK; // [R15] [R12]

    // Offer to the core; drop for one cycle after a take so it is not repeated
    s_next.req   = win_ok && !ack; // [R11]
    s_next.num   = arb_p.win_num; // [R10]
    // Base is 256-byte aligned and 4*59 fits below that
    s_next.vaddr = {s_reg.base[31:8], arb_p.win_num, 2'b00}; // [R1] [R2]

    if (i_srst) begin
      s_next        = '0;
      s_next.base   = evp_pkg::BASE_RST; // [R4]
      s_next.en     = evp_pkg::EN_RST;
      s_next.prio   = {evp_pkg::NUM_EXC{evp_pkg::PRIO_RST}}; // [R8]
    end
  end

  always_ff @(posedge i_clk) begin
    s_reg <= s_next;
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  assign o_exc_req          = s_reg.req;
  assign o_exc_num          = s_reg.num;
  assign o_vec_addr         = s_reg.vaddr;
  assign o_sp_fetch_addr    = s_reg.base; // [R1]
  assign o_reset_fetch_addr = {s_reg.base[31:3], 3'h4}; // [R4]
  assign o_s_axi_awready    = !s_reg.aw_full && !s_reg.bvalid;
  assign o_s_axi_wready     = !s_reg.w_full && !s_reg.bvalid;
  assign o_s_axi_bvalid     = s_reg.bvalid;
  assign o_s_axi_bresp      = s_reg.bresp;
  assign o_s_axi_arready    = !s_reg.rvalid;
  assign o_s_axi_rvalid     = s_reg.rvalid;
  assign o_s_axi_rdata      = s_reg.rdata;
  assign o_s_axi_rresp      = s_reg.rresp;

endmodule
`default_nettype wire

// File: evp_pkg.sv
// Constants shared by the exception vector and priority unit
package evp_pkg;

  // ---------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------
  localparam int NUM_EXC  = 60;
  localparam int NUM_IRQ  = 44;
  localparam int IRQ_BASE = 16;
  localparam int LVL_W    = 4;
  localparam int NUM_W    = 6;

  // ---------------------------------------------------------------------
  // Register offsets (byte addresses; OFS_PRIO_HI is the value of address bits 7:5)
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFS_VECBASE = 8'h00;
  localparam logic [7:0] OFS_EN_LO   = 8'h04;
  localparam logic [7:0] OFS_EN_HI   = 8'h08;
  localparam logic [7:0] OFS_PSET_LO = 8'h0c;
  localparam logic [7:0] OFS_PSET_HI = 8'h10;
  localparam logic [7:0] OFS_PCLR_LO = 8'h14;
  localparam logic [7:0] OFS_PCLR_HI = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1c;
  localparam logic [2:0] OFS_PRIO_HI = 3'h1;
  localparam logic [7:0] OFS_ACT_LO  = 8'h40;
  localparam logic [7:0] OFS_ACT_HI  = 8'h44;

  // ---------------------------------------------------------------------
  // Status word field positions
  // ---------------------------------------------------------------------
  localparam int ST_ACT_NUM  = 0;
  localparam int ST_ACT_LVL  = 8;
  localparam int ST_PEND_NUM = 16;
  localparam int ST_PEND_LVL = 24;
  localparam int ST_PEND_OK  = 31;

  // ---------------------------------------------------------------------
  // Reset values and masks
  // ---------------------------------------------------------------------
  localparam logic [31:0]        BASE_RST  = 32'h0000_0000;
  localparam logic [31:0]        BASE_MASK = 32'h3fff_ff00;
  localparam logic [2:0]         PRIO_RST  = 3'h0;
  localparam logic [NUM_IRQ-1:0] EN_RST    = 44'h000_0000_0000;
  localparam logic [59:0]        IMPL_MASK = 60'h83f_f1ff_c1ff_d87c;
  localparam logic [59:0]        FIXED_MASK = 60'h000_0000_0000_000c;
  localparam logic [59:0]        CFG_MASK  = IMPL_MASK & ~FIXED_MASK;

  // ---------------------------------------------------------------------
  // Exception numbers and urgency ranks (smaller is more urgent)
  // ---------------------------------------------------------------------
  localparam logic [NUM_W-1:0] EXC_NMI   = 6'h02;
  localparam logic [NUM_W-1:0] EXC_HARD  = 6'h03;
  localparam logic [LVL_W-1:0] LVL_RESET = 4'h0;
  localparam logic [LVL_W-1:0] LVL_NMI   = 4'h1;
  localparam logic [LVL_W-1:0] LVL_HARD  = 4'h2;
  localparam logic [LVL_W-1:0] LVL_CFG0  = 4'h3;
  localparam logic [LVL_W-1:0] LVL_THREAD = 4'hf;

  // ---------------------------------------------------------------------
  // AXI responses
  // ---------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// File: evp_arb_if.sv
// Request set and winner between the unit and its arbiter
`timescale 1ns/100ps
`default_nettype none
interface evp_arb_if #(
  parameter int N  = 60,
  parameter int LW = 4,
  parameter int NW = 6
);
  logic [N-1:0]         req;
  logic [N-1:0][LW-1:0] lvl;
  logic                 found;
  logic [NW-1:0]        win_num;
  logic [LW-1:0]        win_lvl;

  modport client  (output req, output lvl, input found, input win_num, input win_lvl);
  modport arbiter (input req, input lvl, output found, output win_num, output win_lvl);
endinterface
`default_nettype wire

// File: evp_arbiter.sv
// Most urgent request finder, lowest number wins a tie
`timescale 1ns/100ps
`default_nettype none
module evp_arbiter #(
  parameter int N  = 60,
  parameter int LW = 4,
  parameter int NW = 6
) (
  evp_arb_if.arbiter arb
);

  // -----------------------------------------------------------------------
  // Search
  // -----------------------------------------------------------------------
  // Scanning upward with a strict compare keeps the lowest number on a tie
  always_comb begin
    arb.found   = 1'b0;
    arb.win_num = '0;
    arb.win_lvl = '1;
    for (int i = 0; i < N; i++) begin
      if (arb.req[i] && (!arb.found || arb.lvl[i] < arb.win_lvl)) begin // [R10]
        arb.found   = 1'b1;
        arb.win_num = NW'(i);
        arb.win_lvl = arb.lvl[i];
      end
    end
  end

endmodule
`default_nettype wire

// File: evp_core_model.sv
// Behavioural model of the core's exception entry and return logic
`timescale 1ns/100ps
`default_nettype none
module evp_core_model (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_exc_req,
  input  wire logic [5:0] i_exc_num,
  input  wire logic       i_ack_en,
  input  wire logic       i_ret_req,
  output logic            o_exc_ack,
  output logic            o_exc_ret,
  output logic [5:0]      o_ret_num
);
  logic [5:0] stk [$];

  // -------------------------------------------------------------------
  // Entry takes a standing offer, return unwinds the newest handler
  // -------------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_exc_ack <= 1'b0;
      o_exc_ret <= 1'b0;
      o_ret_num <= 6'h00;
      stk.delete();
    end else begin
      o_exc_ack <= i_exc_req && i_ack_en && !o_exc_ack;
      if (o_exc_ack && i_exc_req) begin
        stk.push_back(i_exc_num);
      end
      o_exc_ret <= 1'b0;
      if (i_ret_req && stk.size() > 0) begin
        o_exc_ret <= 1'b1;
        o_ret_num <= stk.pop_back();
      end else begin
        // Number is only meaningful with the return strobe
        o_ret_num <= ~o_ret_num;
      end
    end
  end
endmodule
`default_nettype wire

// File: evp_properties.sv
// Port-level properties of the exception vector and priority unit
`timescale 1ns/100ps
`default_nettype none
module evp_properties (
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic        i_nmi,
  input wire logic        i_exc_ack,
  input wire logic        o_exc_req,
  input wire logic [5:0]  o_exc_num,
  input wire logic [31:0] o_vec_addr,
  input wire logic [31:0] o_sp_fetch_addr,
  input wire logic [31:0] o_reset_fetch_addr,
  input wire logic        i_s_axi_arvalid,
  input wire logic        o_s_axi_arready,
  input wire logic        o_s_axi_rvalid,
  input wire logic        i_s_axi_rready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic        o_s_axi_bvalid,
  input wire logic        i_s_axi_bready,
  input wire logic [1:0]  o_s_axi_bresp
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  AST_OFFER_DROP: assert property (o_exc_req && i_exc_ack |=> !o_exc_req)
    else $error("offer still up after entry");
  AST_VEC_MAP: assert property (o_exc_req && $stable(o_sp_fetch_addr) |->
    o_vec_addr == {o_sp_fetch_addr[31:8], o_exc_num, 2'b00}) else $error("vector address");
  AST_SP_ENTRY: assert property (!$past(i_srst) && $stable(o_sp_fetch_addr) |->
    o_reset_fetch_addr == o_sp_fetch_addr + 32'h4) else $error("reset entry address");
  AST_NO_SP_OFFER: assert property (o_exc_req |-> o_exc_num > 6'h01)
    else $error("entry zero offered");
  AST_BASE_RANGE: assert property ((o_sp_fetch_addr & ~32'h3fff_ff00) == 32'h0)
    else $error("table base out of range");
  AST_BASE_RESET: assert property ($fell(i_srst) |-> o_sp_fetch_addr == 32'h0)
    else $error("table base not zero after reset");
  AST_NMI_OFFER: assert property ($rose(i_nmi) |->
    ##[2:6] (o_exc_req && o_exc_num == 6'h02)) else $error("nmi not offered");
  AST_AR_ANSWER: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read not answered");
  AST_R_HOLD: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
    o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read data dropped");
  AST_B_HOLD: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
    o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("write response dropped");
endmodule
bind evp_top evp_properties u_evp_properties (.i_clk(i_clk), .i_srst(i_srst), .i_nmi(i_nmi),
  .i_exc_ack(i_exc_ack), .o_exc_req(o_exc_req), .o_exc_num(o_exc_num),
  .o_vec_addr(o_vec_addr), .o_sp_fetch_addr(o_sp_fetch_addr),
  .o_reset_fetch_addr(o_reset_fetch_addr), .i_s_axi_arvalid(i_s_axi_arvalid),
  .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rvalid(o_s_axi_rvalid),
  .i_s_axi_rready(i_s_axi_rready), .o_s_axi_rdata(o_s_axi_rdata),
  .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
  .o_s_axi_bresp(o_s_axi_bresp));
`default_nettype wire

// File: tb_top.sv
// Self-checking testbench of the exception vector and priority unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_top;
  localparam logic [1:0] OK = evp_pkg::RESP_OKAY;
  localparam logic [5:0] SC [7] = '{6'd4, 6'd5, 6'd6, 6'd11, 6'd12, 6'd14, 6'd15};
  logic        i_clk, i_srst, i_nmi, ack, ret, ack_en, ret_req, req;
  logic [43:0] i_irq;
  logic [15:0] i_sys_exc;
  logic [5:0]  num, ret_num, en;
  logic [31:0] vec, sp_a, rst_a, base, wdata, rdata;
  logic [7:0]  awaddr, araddr;
  logic [2:0]  awprot, arprot;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  logic [33:0] axq [$];
  logic [33:0] nxt;
  logic [5:0]  xq [$];
  int          errors, check_count, seed, k;

  evp_top u_evp_top (.i_clk(i_clk), .i_srst(i_srst), .i_irq(i_irq), .i_nmi(i_nmi),
    .i_sys_exc(i_sys_exc), .o_exc_req(req), .o_exc_num(num), .o_vec_addr(vec),
    .i_exc_ack(ack), .i_exc_ret(ret), .i_ret_num(ret_num), .o_sp_fetch_addr(sp_a),
    .o_reset_fetch_addr(rst_a), .i_s_axi_awaddr(awaddr), .i_s_axi_awprot(awprot),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arprot(arprot), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready));
  evp_core_model u_evp_core_model (.i_clk(i_clk), .i_srst(i_srst), .i_exc_req(req),
    .i_exc_num(num), .i_ack_en(ack_en), .i_ret_req(ret_req), .o_exc_ack(ack),
    .o_exc_ret(ret), .o_ret_num(ret_num));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // -------------------------------------------------------------------
  // Bus and core tasks
  // -------------------------------------------------------------------
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic p,
                     input logic [1:0] r, input logic [3:0] s = 4'hf);
    bit aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    axq.push_back({r, 32'h0});
    awaddr <= a; awprot <= {2'b00, p}; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1;
    wstrb <= s;
    while (!(aw_done && w_done)) begin
      @(posedge i_clk);
      if (awvalid && awready) begin aw_done = 1; awvalid <= 1'b0; end
      if (wvalid && wready) begin w_done = 1; wvalid <= 1'b0; end
    end
    if ($random(seed) & 1) @(posedge i_clk);
    bready <= 1'b1;
    do @(posedge i_clk); while (!(bvalid && bready));
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    axq.push_back({r, d});
    araddr <= a; arprot <= 3'($random(seed)); arvalid <= 1'b1;
    do @(posedge i_clk); while (!arready);
    arvalid <= 1'b0;
    if ($random(seed) & 1) @(posedge i_clk);
    rready <= 1'b1;
    do @(posedge i_clk); while (!(rvalid && rready));
    rready <= 1'b0;
  endtask

  task automatic fire(input logic [43:0] m, input logic [15:0] s, input logic n);
    i_irq <= m; i_sys_exc <= s; i_nmi <= n;
    @(posedge i_clk);
    i_irq <= 44'h0; i_sys_exc <= 16'h0; i_nmi <= 1'b0;
  endtask

  task automatic wait_take;
    while (xq.size() != 0) @(posedge i_clk);
    @(posedge i_clk);
  endtask

  task automatic ret1;
    ret_req <= 1'b1;
    @(posedge i_clk);
    ret_req <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic end_of_test;
    if (errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // -------------------------------------------------------------------
  // Result watcher
  // -------------------------------------------------------------------
  always @(posedge i_clk) begin
    ack_en <= |($random(seed) & 32'h3);
    if (bvalid && bready) begin nxt = axq.pop_front(); `CHK(bresp, nxt[33:32]) end
    if (rvalid && rready) begin nxt = axq.pop_front(); `CHK({rresp, rdata}, nxt) end
    if (req && ack) begin
      if (xq.size() == 0) begin errors++; $display("BAD %0t unexpected entry", $time); end
      else begin
        en = xq.pop_front();
        `CHK(num, en)
        `CHK(vec, {base[31:8], en, 2'b00})
        `CHK(vec[1:0], 2'b00)
      end
    end
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    errors++;
    end_of_test;
  end

  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  initial begin
    seed = 86261; errors = 0; check_count = 0; base = 32'h0; i_srst = 1'b1;
    i_irq = 44'h0; i_sys_exc = 16'h0; i_nmi = 1'b0; ack_en = 1'b0; ret_req = 1'b0;
    awaddr = 8'h00; awprot = 3'h0; awvalid = 1'b0; wdata = 32'h0; wvalid = 1'b0;
    wstrb = 4'hf;
    bready = 1'b0; araddr = 8'h00; arprot = 3'h0; arvalid = 1'b0; rready = 1'b0;
    repeat (12) @(posedge i_clk);
    i_srst <= 1'b0;
    axr(8'h00, 32'h0, OK);
    for (int w = 0; w < 8; w++) axr(8'h20 + 8'(4 * w), 32'h0, OK);
    `CHK(sp_a, 32'h0)
    `CHK(rst_a, 32'h4)
    axr(8'h80, 32'h0, evp_pkg::RESP_DECERR);
    axw(8'h00, 32'h1234_5600, 1'b0, evp_pkg::RESP_SLVERR);
    axr(8'h00, 32'h0, OK);
    axw(8'h00, 32'hffff_ffff, 1'b1, OK);
    base = 32'h3fff_ff00;
    axr(8'h00, base, OK);
    axw(8'h04, 32'hffff_ffff, 1'b1, OK);
    axw(8'h08, 32'h0000_0fff, 1'b1, OK);
    axw(8'h28, 32'hffff_ffff, 1'b1, OK);
    axr(8'h28, 32'h7777_7777, OK);
    axw(8'h2c, 32'hffff_ffff, 1'b1, OK, 4'h1);
    axr(8'h2c, 32'h0000_0007, OK);
    for (int i = 0; i < 6; i++) begin
      k = (i == 5) ? 43 : $unsigned($random(seed)) % 44;
      while ((k >= 9 && k <= 13) || (k >= 25 && k <= 27) || (k >= 38 && k <= 42)) k++;
      xq.push_back(6'(16 + k));
      fire(44'h1 << k, 16'h0, 1'b0);
      wait_take;
      ret1;
    end
    axw(8'h28, 32'h0, 1'b1, OK);
    xq.push_back(6'd16);
    fire(44'h3, 16'h0, 1'b0);
    wait_take;
    axr(8'h1c, 32'h8311_0310, OK);
    xq.push_back(6'd17);
    ret1; wait_take; ret1;
    axw(8'h28, 32'h0000_0025, 1'b1, OK);
    xq.push_back(6'd16);
    fire(44'h1, 16'h0, 1'b0);
    wait_take;
    xq.push_back(6'd17);
    fire(44'h2, 16'h0, 1'b0);
    wait_take; ret1; ret1;
    xq.push_back(6'd17);
    fire(44'h3, 16'h0, 1'b0);
    wait_take;
    xq.push_back(6'd16);
    ret1; wait_take; ret1;
    axw(8'h00, 32'h0000_0100, 1'b1, OK);
    base = 32'h0000_0100;
    axr(8'h00, base, OK);
    xq.push_back(6'd16);
    fire(44'h1, 16'h0, 1'b0);
    wait_take;
    xq.push_back(6'd2);
    fire(44'h0, 16'h0, 1'b1);
    wait_take;
    fire(44'h0, 16'h0008, 1'b0);
    repeat (2) @(posedge i_clk);
    axr(8'h1c, 32'h8203_0102, OK);
    xq.push_back(6'd3);
    ret1; wait_take; ret1; ret1;
    xq.push_back(SC[0]);
    fire(44'h0, 16'hd870, 1'b0);
    for (int j = 0; j < 7; j++) begin
      wait_take;
      if (j < 6) xq.push_back(SC[j + 1]);
      ret1;
    end
    `CHK(xq.size(), 0)
    i_srst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
    base = 32'h0;
    axr(8'h00, base, OK);
    axr(8'h28, 32'h0, OK);
    end_of_test;
  end
endmodule
`default_nettype wire
